/* File: cms_channel_select.sv */
// Channel mask selector: availability map, enable mask and active set
`timescale 1ns/1ps
module cms_channel_select #(
  parameter logic [63:0] AVAIL_MAP = cms_pkg::AVAIL_NA,
  parameter logic [6:0]  MIN_COUNT = cms_pkg::MIN_CNT_NA
) (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        MASK_WR,
  input  wire logic [63:0] MASK_WDATA,
  input  wire logic        FACTORY_RESET,
  output logic      [63:0] AVAILABLE_CHANNEL_MAP,
  output logic      [63:0] CHANNEL_ENABLE_MASK,
  output logic      [6:0]  MIN_CHANNEL_COUNT,
  output logic      [63:0] ACTIVE_CHANNELS,
  output logic      [6:0]  ELIGIBLE_COUNT,
  output logic             WR_DONE,
  output logic             WR_ERROR
);
  localparam int N = cms_pkg::NUM_CH;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [63:0] mask_q;
  logic [63:0] active_q;
  logic [6:0]  elig_cnt_q;
  logic        done_q;
  logic        err_q;

  // ****************************************************************
  // Eligibility and selection
  // ****************************************************************
  // Constant map: nothing ever writes it, so it is a wire
  wire  [63:0] avail_map = AVAIL_MAP;
  wire  [63:0] new_elig  = MASK_WDATA & avail_map;
  wire  [63:0] cur_elig  = mask_q & avail_map;
  logic [6:0]  new_rank [N+1];
  logic [6:0]  cur_rank [N+1];
  logic [63:0] cur_sel;

  // Running prefix counts; a channel is kept while its rank is below the minimum
  assign new_rank[0] = '0;
  assign cur_rank[0] = '0;
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_rank
      assign new_rank[gi+1] = new_rank[gi] + {6'h00, new_elig[gi]};
      assign cur_rank[gi+1] = cur_rank[gi] + {6'h00, cur_elig[gi]};
      assign cur_sel[gi]    = cur_elig[gi] && (cur_rank[gi] < MIN_COUNT);
    end
  endgenerate

  // Long carry chain traded for zero latency; fine at 250 MHz for 64 bits in most nodes
  wire new_short = new_rank[N] < MIN_COUNT;

  // ****************************************************************
  // Mask storage and write answer
  // ****************************************************************
  // Factory restore wins over a write in the same cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      mask_q <= cms_pkg::MASK_RESET;
    end else if (FACTORY_RESET) begin
      mask_q <= cms_pkg::MASK_RESET;
    end else if (MASK_WR && !new_short) begin
      mask_q <= MASK_WDATA;
    end
  end

  // One-cycle answer pulses after each write that no factory restore swallows in the same cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      done_q <= MASK_WR && !FACTORY_RESET;
      err_q  <= MASK_WR && !FACTORY_RESET && new_short;
    end
  end

  // Registered active set for the hopper
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      active_q   <= '0;
      elig_cnt_q <= '0;
    end else begin
      active_q   <= cur_sel;
      elig_cnt_q <= cur_rank[N];
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign AVAILABLE_CHANNEL_MAP = avail_map;
  assign CHANNEL_ENABLE_MASK   = mask_q;
  assign MIN_CHANNEL_COUNT     = MIN_COUNT;
  assign ACTIVE_CHANNELS       = active_q;
  assign ELIGIBLE_COUNT        = elig_cnt_q;
  assign WR_DONE               = done_q;
  assign WR_ERROR              = err_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_bad_write;
    MASK_WR && !FACTORY_RESET && new_short;
  endsequence

  reject_keeps_mask_a: assert property (@(posedge CLK) disable iff (!NRST)
    s_bad_write |=> (mask_q == $past(mask_q)))
    else $error("rejected write changed the mask");

  reject_flags_err_a: assert property (@(posedge CLK) disable iff (!NRST)
    s_bad_write |=> (WR_ERROR && WR_DONE))
    else $error("short mask not flagged");

  good_write_ok_a: assert property (@(posedge CLK) disable iff (!NRST)
    (MASK_WR && !FACTORY_RESET && !new_short) |=> (mask_q == $past(MASK_WDATA) && !WR_ERROR))
    else $error("valid mask not stored");

  factory_mask_a: assert property (@(posedge CLK) disable iff (!NRST)
    FACTORY_RESET |=> (mask_q == cms_pkg::MASK_RESET))
    else $error("factory mask wrong");

  active_subset_a: assert property (@(posedge CLK) disable iff (!NRST)
    ((ACTIVE_CHANNELS & ~(mask_q & avail_map)) == '0) || $changed(mask_q))
    else $error("inactive channel selected");

  active_count_a: assert property (@(posedge CLK) disable iff (!NRST)
    $stable(mask_q) |=> ($countones(ACTIVE_CHANNELS) ==
      ((ELIGIBLE_COUNT < MIN_COUNT) ? ELIGIBLE_COUNT : MIN_COUNT)))
    else $error("active count wrong");

  min_range_a: assert property (@(posedge CLK) disable iff (!NRST)
    MIN_CHANNEL_COUNT >= cms_pkg::MIN_CNT_LO && MIN_CHANNEL_COUNT <= cms_pkg::MIN_CNT_HI)
    else $error("minimum count out of range");

  avail_fixed_a: assert property (@(posedge CLK) disable iff (!NRST)
    $stable(AVAILABLE_CHANNEL_MAP))
    else $error("availability map changed");

  // ****************************************************************
  // Check helpers
  // ****************************************************************
  // Eligible set as it stood when the active set was last loaded
  // Only the checks below read it, so it costs nothing in the netlist
  logic [63:0] elig_seen_q;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      elig_seen_q <= '0;
    end else begin
      elig_seen_q <= cur_elig;
    end
  end

  // Lowest eligible channel left out, one-hot; zero when none is left out
  wire  [63:0] skipped    = elig_seen_q & ~ACTIVE_CHANNELS;
  wire  [63:0] first_skip = skipped & (~skipped + 64'h1);
  // All channels below the first one left out; all ones when none is
  wire  [63:0] below_skip = first_skip - 64'h1;

  // Write taken and accepted
  sequence s_good_write;
    MASK_WR && !FACTORY_RESET && !new_short;
  endsequence

  // Write answered without an error
  sequence s_ok_answer;
    WR_DONE && !WR_ERROR;
  endsequence

  // Write that a factory restore in the same cycle swallows
  sequence s_lost_write;
    MASK_WR && FACTORY_RESET;
  endsequence

  // Neither a write nor a restore this cycle
  sequence s_idle;
    !MASK_WR && !FACTORY_RESET;
  endsequence

  // Shape of the active set against the eligible set it was built from
  active_eligible_a: assert property (@(posedge CLK) disable iff (!NRST)
    (ACTIVE_CHANNELS & ~elig_seen_q) == '0)
    else $error("active channel not eligible");

  active_lowest_a: assert property (@(posedge CLK) disable iff (!NRST)
    (ACTIVE_CHANNELS & ~below_skip) == '0)
    else $error("higher channel used over a lower one");

  // Write answers and custody of the stored mask
  stored_enough_a: assert property (@(posedge CLK) disable iff (!NRST)
    s_good_write |=> s_ok_answer ##1 (ELIGIBLE_COUNT >= MIN_COUNT))
    else $error("stored mask below the minimum");

  lost_write_quiet_a: assert property (@(posedge CLK) disable iff (!NRST)
    s_lost_write |=> (!WR_DONE && !WR_ERROR && mask_q == cms_pkg::MASK_RESET))
    else $error("write answered during factory restore");

  error_needs_done_a: assert property (@(posedge CLK) disable iff (!NRST)
    WR_ERROR |-> WR_DONE)
    else $error("error flagged without a write answer");

  done_needs_write_a: assert property (@(posedge CLK) disable iff (!NRST)
    WR_DONE |-> ($past(MASK_WR) && !$past(FACTORY_RESET)))
    else $error("write answer without a write");

  // A mask may only move by an accepted write or a restore
  mask_holds_a: assert property (@(posedge CLK) disable iff (!NRST)
    s_idle |=> $stable(mask_q))
    else $error("mask changed with no write");
endmodule

/* File: cms_pkg.sv */
// Package for the channel mask selector: widths, reset values, channel plan
package cms_pkg;
  // ****************************************************************
  // Channel plan
  // ****************************************************************
  localparam int          NUM_CH        = 64;
  localparam int          CNT_W         = 7;
  localparam int          BASE_KHZ      = 902400;  // Channel 0 centre
  localparam int          STEP_KHZ      = 400;     // Channel spacing
  localparam int          TOP_KHZ       = 927600;  // Channel 63 centre
  localparam logic [63:0] MASK_RESET    = 64'hFFFF_FFFF_FFF7_FFFF;  // Channel 19 off
  localparam logic [63:0] AVAIL_NA      = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [6:0]  MIN_CNT_NA    = 7'h19;   // 25 channels
  localparam logic [6:0]  MIN_CNT_LO    = 7'h01;
  localparam logic [6:0]  MIN_CNT_HI    = 7'h32;   // 50 channels
endpackage

/* File: cms_host.sv */
// Host model that issues channel mask writes
`timescale 1ns/1ps
module cms_host (
  input  wire logic        CLK,
  input  wire logic        REQ,
  input  wire logic [63:0] DATA,
  output logic             MASK_WR = 1'b0,
  output logic      [63:0] MASK_WDATA = '0
);
  // Strobe per request; idle data inverts so a stale word never looks valid
  always @(negedge CLK) begin
    MASK_WR    <= REQ;
    MASK_WDATA <= REQ ? DATA : ~MASK_WDATA;
  end
endmodule

/* File: tb.sv */
// Bench comparing the channel mask selector with an integer model
`timescale 1ns/1ps
module tb;
  localparam logic [63:0] AV = 64'hF0FF_FFFF_FE00_0FFF;  // Sparse map with top channel
  logic        clk = 0, nrst = 0, fr = 0, req = 0, wr, dn, er;
  logic [63:0] d = 0, wd, av, msk, act, m, v;
  logic [6:0]  mc, ec;
  logic [15:0] r = 16'h48;
  int          n_fail = 0, samples_checked = 0;
  always #2 clk = ~clk;
  cms_host u_host (.CLK(clk), .REQ(req), .DATA(d), .MASK_WR(wr), .MASK_WDATA(wd));
  cms_channel_select #(.AVAIL_MAP(AV)) u_dut (.CLK(clk), .NRST(nrst), .MASK_WR(wr),
    .MASK_WDATA(wd), .FACTORY_RESET(fr), .AVAILABLE_CHANNEL_MAP(av),
    .CHANNEL_ENABLE_MASK(msk), .MIN_CHANNEL_COUNT(mc), .ACTIVE_CHANNELS(act),
    .ELIGIBLE_COUNT(ec), .WR_DONE(dn), .WR_ERROR(er));
  // Model helpers
  function automatic logic [15:0] nx(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int pc(logic [63:0] x);
    int n = 0;
    for (int i = 0; i < 64; i++)
      n += x[i];
    return n;
  endfunction
  function automatic logic [63:0] sel(logic [63:0] x);  // Lowest 25 eligible
    logic [63:0] y = '0;
    int n = 0;
    for (int i = 0; i < 64; i++)
      if (x[i] && n < 25) begin
        y[i] = 1'b1;
        n++;
      end
    return y;
  endfunction
  task automatic chk(logic [63:0] s, logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  // Stored mask now, derived set one cycle later
  task automatic res_chk();
    chk(msk, m);
    @(negedge clk);
    chk(act, sel(m & AV));
    chk(ec, 64'(pc(m & AV)));
  endtask
  task automatic wrt(logic [63:0] x);
    logic bad;
    bad = pc(x & AV) < 25;
    @(posedge clk) #1;
    req = 1;
    d = x;
    @(posedge clk) #1 req = 0;
    @(negedge clk) chk(dn, 1);
    chk(er, bad);
    if (!bad) m = x;
    res_chk();
  endtask
  task automatic results();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1;
    m = cms_pkg::MASK_RESET;
    @(negedge clk);
    chk(av, AV);
    chk(mc, 25);
    res_chk();
    $display("reset test done");
    wrt(64'h0);
    wrt(64'hF000_0003_FE00_0FFF);  // Exactly 25 eligible, bit 63 bounds
    wrt(64'h7000_0003_FE00_0FFF);  // One short
    @(negedge clk) fr = 1;
    @(negedge clk) fr = 0;
    m = cms_pkg::MASK_RESET;
    res_chk();
    $display("boundary test done");
    for (int k = 0; k < 20; k++) begin
      for (int j = 0; j < 4; j++) begin
        r = nx(r);
        v = {v[47:0], r};
      end
      wrt(v | (v << 1));
    end
    $display("random test done");
    // Restore in the same cycle as a good write: no answer, reset mask
    @(posedge clk) #1;
    req = 1;
    d = 64'hF000_0003_FE00_0FFF;
    @(negedge clk) fr = 1;
    @(posedge clk) #1 req = 0;
    @(negedge clk) fr = 0;
    chk(dn, 0);
    chk(er, 0);
    m = cms_pkg::MASK_RESET;
    res_chk();
    $display("restore test done");
    // Reset in mid-run after the mask has moved away from its reset value
    wrt(64'hF000_0003_FE00_0FFF);
    @(negedge clk) nrst = 0;
    @(negedge clk);
    chk(msk, cms_pkg::MASK_RESET);
    chk(act, 0);
    chk(ec, 0);
    chk(dn, 0);
    nrst = 1;
    m = cms_pkg::MASK_RESET;
    res_chk();
    $display("mid-run reset test done");
    results();
  end
  initial begin
    #20000;
    n_fail++;
    results();
  end
endmodule
